// [step_dir_microstep_sequencer.sv]
// Step/dir front end of a two-phase stepper driver with AXI4-Lite configuration.
// Assumes step, direction and configuration pins are synchronous to aclk.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`include "step_sequencer_defines.svh"

module step_dir_microstep_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic step,
  input wire logic direction,
  input wire logic double_edge_step_select,
  input wire logic resolution_select_lo,
  input wire logic resolution_select_hi,
  input wire logic powerdown_serial_pin,
  input wire logic drive_disable_n,
  input wire logic chopper_select_pin,
  input wire logic ext_clk_level,
  output logic [9:0] microstep_position_count,
  output logic signed [8:0] coil_a_setpoint,
  output logic signed [8:0] coil_b_setpoint,
  output logic [4:0] current_scale,
  output logic power_stage_enable,
  output logic freewheel,
  output logic brake,
  output logic cycle_chopper,
  output logic index_pulse,
  output logic ext_clock_active
);

  typedef struct packed {
    step_sequencer_pkg::bus_state_type bus;
    logic aw_seen;
    logic w_seen;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] control;
    logic signed [31:0] velocity;
    logic [31:0] standstill;
    logic step_prev;
    logic ext_prev;
    logic [31:0] gen_accum;
    logic [9:0] position;
    step_sequencer_pkg::hold_state_type hold;
    logic [7:0] unit_count;
    logic [7:0] delay_count;
    logic [3:0] decay_count;
    logic [4:0] scale;
    logic [7:0] ext_count;
    logic ext_ok;
    logic index;
    logic enable;
    logic fw;
    logic brk;
    logic chop;
    step_sequencer_pkg::coil_setpoint_type coils;
  } state_type;

  state_type state;
  state_type next_state;
  step_sequencer_pkg::coil_setpoint_type table_out;

  // Step size is 256 >> log2(microsteps); encoding 0 = 256 microsteps, 8 = full step
  function automatic logic [9:0] step_size(input logic [3:0] res);
    begin
      step_size = (res > 4'h8) ? 10'h100 : 10'(10'h001 << res);
    end
  endfunction

  // Pin resolution decode to the same encoding
  function automatic logic [3:0] pin_resolution(input logic hi, input logic lo);
    begin
      case ({hi, lo})
        2'b00: pin_resolution = 4'h5;
        2'b01: pin_resolution = 4'h3;
        2'b10: pin_resolution = 4'h2;
        default: pin_resolution = 4'h4;
      endcase
    end
  endfunction

  // Coil setpoints follow the registered position one cycle later
  sine_table table_inst (
    .position(state.position),
    .setpoint(table_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic wr_fire;
    logic [11:0] raddr;
    logic ext_edge;
    logic gen_step;
    logic gen_dir;
    logic [32:0] gen_sum;
    logic [31:0] speed;
    logic [3:0] res;
    logic [9:0] delta;
    logic moved;
    logic [4:0] hold_scale;
    wr_fire = 1'b0;
    raddr = s_axi_araddr[11:0];
    ext_edge = 1'b0;
    gen_step = 1'b0;
    gen_dir = 1'b0;
    gen_sum = 33'h0;
    speed = 32'h0;
    res = 4'h0;
    delta = 10'h0;
    moved = 1'b0;
    hold_scale = 5'h0;
    next_state = state;

    // Register bus: accepts address and data in either order
    case (state.bus)
      step_sequencer_pkg::bus_idle: begin
        if (s_axi_awvalid && !state.aw_seen) begin
          next_state.aw_seen = 1'b1;
          next_state.waddr = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && !state.w_seen) begin
          next_state.w_seen = 1'b1;
          next_state.wdata = s_axi_wdata;
          next_state.wstrb = s_axi_wstrb;
        end
        // A read taken with arready high wins; a write caught in the same cycle completes after it
        if (s_axi_arvalid && !state.aw_seen && !state.w_seen) begin
          next_state.rresp = `AXI_OKAY;
          case (raddr)
            `ADDR_CONTROL: next_state.rdata = state.control;
            `ADDR_VELOCITY: next_state.rdata = state.velocity;
            `ADDR_STANDSTILL: next_state.rdata = state.standstill;
            `ADDR_STATUS: next_state.rdata = {26'h0, state.hold == step_sequencer_pkg::hold_reduced,
                                              state.chop, state.ext_ok, state.fw, state.brk, state.enable};
            `ADDR_POSITION: next_state.rdata = {22'h0, state.position};
            default: begin
              next_state.rdata = 32'h0;
              next_state.rresp = `AXI_SLVERR;
            end
          endcase
          next_state.bus = step_sequencer_pkg::bus_read_resp;
        end else if (next_state.aw_seen && next_state.w_seen) begin
          wr_fire = 1'b1;
          next_state.aw_seen = 1'b0;
          next_state.w_seen = 1'b0;
          next_state.bus = step_sequencer_pkg::bus_write_resp;
        end
      end
      step_sequencer_pkg::bus_write_resp: begin
        if (s_axi_bready) begin
          next_state.bus = step_sequencer_pkg::bus_idle;
        end
      end
      step_sequencer_pkg::bus_read_resp: begin
        if (s_axi_rready) begin
          next_state.bus = step_sequencer_pkg::bus_idle;
        end
      end
      default: next_state.bus = step_sequencer_pkg::bus_idle;
    endcase

    if (wr_fire) begin
      next_state.bresp = `AXI_OKAY;
      for (int b = 0; b < 4; b++) begin
        if (next_state.wstrb[b]) begin
          case (next_state.waddr)
            `ADDR_CONTROL: next_state.control[b*8 +: 8] = next_state.wdata[b*8 +: 8];
            // New velocity takes effect immediately, no ramp
            `ADDR_VELOCITY: next_state.velocity[b*8 +: 8] = next_state.wdata[b*8 +: 8];
            `ADDR_STANDSTILL: next_state.standstill[b*8 +: 8] = next_state.wdata[b*8 +: 8];
            default: next_state.bresp = next_state.bresp;
          endcase
        end
      end
      if (next_state.waddr != `ADDR_CONTROL && next_state.waddr != `ADDR_VELOCITY
          && next_state.waddr != `ADDR_STANDSTILL) begin
        next_state.bresp = `AXI_SLVERR;
      end
    end

    // Active step edge detection
    next_state.step_prev = step;
    if (double_edge_step_select || state.control[`CTL_DOUBLE_EDGE]) begin
      ext_edge = step ^ state.step_prev;
    end else begin
      ext_edge = step & ~state.step_prev;
    end

    // Internal generator: phase accumulator at signed velocity
    speed = state.velocity[31] ? 32'(-state.velocity) : state.velocity;
    gen_dir = state.velocity[31];
    if (state.control[`CTL_INTERNAL_GEN]) begin
      gen_sum = {1'b0, state.gen_accum} + {1'b0, speed};
      gen_step = gen_sum[32];
      next_state.gen_accum = gen_sum[31:0];
    end else begin
      next_state.gen_accum = 32'h0;
    end

    // Resolution from register or pins
    res = state.control[`CTL_SERIAL_RES] ? state.control[`CTL_RES_MSB:`CTL_RES_LSB]
                                         : pin_resolution(resolution_select_hi, resolution_select_lo);
    delta = step_size(res);

    // External steps move the position in the dir sampled at the edge, internal steps by the velocity sign; an external step wins a shared cycle
    if (ext_edge) begin
      next_state.position = direction ? 10'(state.position - delta) : 10'(state.position + delta);
      moved = 1'b1;
    end else if (gen_step) begin
      next_state.position = gen_dir ? 10'(state.position - delta) : 10'(state.position + delta);
      moved = 1'b1;
    end

    // Index near zero, once per 1024 positions
    // Only entry into the window pulses, so fine resolutions still give one pulse per revolution
    next_state.index = moved && (next_state.position < `INDEX_WINDOW) && (state.position >= `INDEX_WINDOW);

    // Standstill reduction with delay and stepwise decay
    hold_scale = state.standstill[`SS_HOLD_MSB:`SS_HOLD_LSB];
    next_state.unit_count = (state.unit_count == 8'(`STANDSTILL_UNIT_CYCLES - 1)) ? 8'h0 : 8'(state.unit_count + 8'h1);
    if (moved || (powerdown_serial_pin && !state.control[`CTL_POWERDOWN_DIS])) begin
      next_state.hold = step_sequencer_pkg::hold_running;
      next_state.scale = `RUN_SCALE;
      next_state.delay_count = 8'h0;
    end else begin
      case (state.hold)
        step_sequencer_pkg::hold_running: next_state.hold = step_sequencer_pkg::hold_waiting;
        step_sequencer_pkg::hold_waiting: begin
          if (state.unit_count == 8'h0) begin
            next_state.delay_count = 8'(state.delay_count + 8'h1);
          end
          if (state.delay_count >= state.standstill[`SS_DELAY_MSB:`SS_DELAY_LSB]) begin
            next_state.hold = step_sequencer_pkg::hold_reduced;
            next_state.decay_count = 4'h0;
          end
        end
        step_sequencer_pkg::hold_reduced: begin
          if (state.unit_count == 8'h0) begin
            next_state.decay_count = 4'(state.decay_count + 4'h1);
            if (state.decay_count >= state.standstill[`SS_DECAY_MSB:`SS_DECAY_LSB] && state.scale > hold_scale) begin
              next_state.scale = 5'(state.scale - 5'h1);
              next_state.decay_count = 4'h0;
            end
          end
          if (state.scale < hold_scale) begin
            next_state.scale = hold_scale;
          end
        end
        default: next_state.hold = step_sequencer_pkg::hold_running;
      endcase
    end
    next_state.fw = (state.hold == step_sequencer_pkg::hold_reduced) && state.control[`CTL_FREEWHEEL]
                    && !state.control[`CTL_BRAKE];
    next_state.brk = (state.hold == step_sequencer_pkg::hold_reduced) && state.control[`CTL_BRAKE];

    // Drive disable switches the stage off
    next_state.enable = !drive_disable_n;

    // Chopper select from pin or configuration
    next_state.chop = state.control[`CTL_CHOPPER_SEL] ? state.control[`CTL_CHOPPER_REG] : chopper_select_pin;

    // External clock watchdog with fallback
    next_state.ext_prev = ext_clk_level;
    if (ext_clk_level != state.ext_prev) begin
      next_state.ext_count = 8'h0;
      next_state.ext_ok = state.control[`CTL_EXT_CLK_SEL];
    end else if (state.ext_count >= 8'(`EXT_CLK_TIMEOUT_CYCLES - 1)) begin
      next_state.ext_ok = 1'b0;
    end else begin
      next_state.ext_count = 8'(state.ext_count + 8'h1);
    end
    if (!state.control[`CTL_EXT_CLK_SEL]) begin
      next_state.ext_ok = 1'b0;
    end

    next_state.coils = table_out;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
      state.control <= `CONTROL_RESET;
      state.velocity <= `VELOCITY_RESET;
      state.standstill <= `STANDSTILL_RESET;
      state.position <= 10'h000;
      state.scale <= `RUN_SCALE;
      state.coils <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    s_axi_awready = (state.bus == step_sequencer_pkg::bus_idle) && !state.aw_seen;
    s_axi_wready = (state.bus == step_sequencer_pkg::bus_idle) && !state.w_seen;
    s_axi_arready = (state.bus == step_sequencer_pkg::bus_idle) && !state.aw_seen && !state.w_seen;
  end

  assign s_axi_bvalid = state.bus == step_sequencer_pkg::bus_write_resp;
  assign s_axi_bresp = state.bresp;
  assign s_axi_rvalid = state.bus == step_sequencer_pkg::bus_read_resp;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign microstep_position_count = state.position;
  assign coil_a_setpoint = state.coils.coil_a;
  assign coil_b_setpoint = state.coils.coil_b;
  assign current_scale = state.scale;
  assign power_stage_enable = state.enable;
  assign freewheel = state.fw;
  assign brake = state.brk;
  assign cycle_chopper = state.chop;
  assign index_pulse = state.index;
  assign ext_clock_active = state.ext_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_rising_step;
    @(posedge aclk) disable iff (!aresetn)
      $rose(step) && !direction && !state.control[`CTL_INTERNAL_GEN] |=> $changed(microstep_position_count);
  endproperty
  a_rising_step: assert property (p_rising_step) else $error("rising step did not move position");

  property p_single_edge;
    @(posedge aclk) disable iff (!aresetn)
      $fell(step) && !double_edge_step_select && !state.control[`CTL_DOUBLE_EDGE]
      && !state.control[`CTL_INTERNAL_GEN] |=> $stable(microstep_position_count);
  endproperty
  a_single_edge: assert property (p_single_edge) else $error("falling step moved position");

  // Step size in force at the edge, for the step-size checks
  logic [9:0] delta_now_q;
  always_ff @(posedge aclk) begin
    delta_now_q <= step_size(state.control[`CTL_SERIAL_RES] ? state.control[`CTL_RES_MSB:`CTL_RES_LSB]
                                                            : pin_resolution(resolution_select_hi, resolution_select_lo));
  end
  property p_forward;
    @(posedge aclk) disable iff (!aresetn)
      $rose(step) && !direction |=> microstep_position_count == 10'($past(microstep_position_count) + delta_now_q);
  endproperty
  a_forward: assert property (p_forward) else $error("forward step size wrong");

  property p_backward;
    @(posedge aclk) disable iff (!aresetn)
      $rose(step) && direction |=> microstep_position_count == 10'($past(microstep_position_count) - delta_now_q);
  endproperty
  a_backward: assert property (p_backward) else $error("backward step size wrong");

  property p_disable;
    @(posedge aclk) disable iff (!aresetn) drive_disable_n |=> !power_stage_enable;
  endproperty
  a_disable: assert property (p_disable) else $error("stage on while disabled");

  property p_index;
    @(posedge aclk) disable iff (!aresetn) index_pulse |-> microstep_position_count < `INDEX_WINDOW;
  endproperty
  a_index: assert property (p_index) else $error("index away from zero");

  property p_chopper_pin;
    @(posedge aclk) disable iff (!aresetn)
      !state.control[`CTL_CHOPPER_SEL] ##1 !state.control[`CTL_CHOPPER_SEL] |-> cycle_chopper == $past(chopper_select_pin);
  endproperty
  a_chopper_pin: assert property (p_chopper_pin) else $error("chopper pin not followed");

  property p_running_current;
    @(posedge aclk) disable iff (!aresetn)
      powerdown_serial_pin && !state.control[`CTL_POWERDOWN_DIS] |=> current_scale == `RUN_SCALE;
  endproperty
  a_running_current: assert property (p_running_current) else $error("current reduced with pin high");

endmodule

// [step_sequencer_defines.svh]
// Constants for the step/dir microstep sequencer: register offsets, fields, reset values, timing.
// Assumes a 100 MHz aclk; included by the design and the bench.
`ifndef STEP_SEQUENCER_DEFINES_SVH
`define STEP_SEQUENCER_DEFINES_SVH

`define ADDR_CONTROL 12'h000
`define ADDR_VELOCITY 12'h004
`define ADDR_STANDSTILL 12'h008
`define ADDR_STATUS 12'h00c
`define ADDR_POSITION 12'h010

// Control register fields
`define CTL_DOUBLE_EDGE 0
`define CTL_INTERNAL_GEN 1
`define CTL_SERIAL_RES 2
`define CTL_RES_LSB 4
`define CTL_RES_MSB 7
`define CTL_CHOPPER_SEL 8
`define CTL_CHOPPER_REG 9
`define CTL_POWERDOWN_DIS 10
`define CTL_FREEWHEEL 11
`define CTL_BRAKE 12
`define CTL_EXT_CLK_SEL 13
`define CONTROL_RESET 32'h0000_0000

// Standstill register fields
`define SS_HOLD_LSB 0
`define SS_HOLD_MSB 4
`define SS_DELAY_LSB 8
`define SS_DELAY_MSB 15
`define SS_DECAY_LSB 16
`define SS_DECAY_MSB 19
`define STANDSTILL_RESET 32'h0004_1012

`define RUN_SCALE 5'h1f
`define VELOCITY_RESET 32'h0000_0000

// Standstill delay unit, in ns, and its cycle count
`define STANDSTILL_UNIT_NS 1000
`define STANDSTILL_UNIT_CYCLES ((`STANDSTILL_UNIT_NS + 9) / 10)
// External clock timeout, in ns, and its cycle count (longest time, rounds down)
`define EXT_CLK_TIMEOUT_NS 2000
`define EXT_CLK_TIMEOUT_CYCLES (`EXT_CLK_TIMEOUT_NS / 10)

`define INDEX_WINDOW 10'h004
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// [step_sequencer_pkg.sv]
// Types shared by the sequencer and its sine table.
// Assumes step_sequencer_defines.svh is on the include path.
package step_sequencer_pkg;

  typedef struct packed {
    logic [9:0] position;
    logic [7:0] sine;
    logic [7:0] cosine;
  } phase_type;

  typedef struct packed {
    logic signed [8:0] coil_a;
    logic signed [8:0] coil_b;
  } coil_setpoint_type;

  typedef enum logic [1:0] {
    bus_idle,
    bus_write_resp,
    bus_read_resp
  } bus_state_type;

  typedef enum logic [1:0] {
    hold_running,
    hold_waiting,
    hold_reduced
  } hold_state_type;

endpackage

// [sine_table.sv]
// Quarter-wave sine table mapping the 10-bit microstep position to signed coil setpoints.
// Assumes position wraps modulo 1024 with 256 entries per quarter wave.
module sine_table (
  input wire logic [9:0] position,
  output step_sequencer_pkg::coil_setpoint_type setpoint
);

  function automatic logic [7:0] quarter_sine(input logic [7:0] idx);
    int value;
    begin
      // Parabolic approximation of sin(idx * pi / 512) scaled to 255
      value = (int'(idx) * (512 - int'(idx)) * 255) / (256 * 256);
      quarter_sine = value[7:0];
    end
  endfunction

  function automatic logic signed [8:0] wave(input logic [9:0] pos);
    logic [7:0] mag;
    begin
      mag = pos[8] ? quarter_sine(8'(9'h100 - {1'b0, pos[7:0]})) : quarter_sine(pos[7:0]);
      if (pos[8] && pos[7:0] == 8'h00) begin
        mag = 8'hff;
      end
      wave = pos[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    end
  endfunction

  // Sine and cosine from one table
  always_comb begin
    setpoint.coil_a = wave(position);
    setpoint.coil_b = wave(10'(position + 10'h100));
  end

endmodule

// [step_source_model.sv]
// Behavioural motion controller that drives the step and direction lines.
// Assumes one-cycle toggle requests on aclk; direction is set a cycle ahead of the step edge.
module step_source_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic toggle_req,
  input wire logic dir_req,
  output logic step,
  output logic direction
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pending;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step <= 1'b0;
      direction <= 1'b0;
      pending <= 1'b0;
    end else begin
      pending <= toggle_req;
      if (toggle_req) begin
        direction <= dir_req;
      end
      // Direction is held from a cycle before the edge until the next request
      if (pending) begin
        step <= ~step;
      end
    end
  end
endmodule

// [tb_top.sv]
// Self-checking bench for the step/dir microstep sequencer.
// Assumes package, defines header, design and step source model are compiled first.
`include "step_sequencer_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic step, direction, toggle_req = 1'b0, dir_req = 1'b0, double_edge_step_select = 1'b0;
  logic resolution_select_lo = 1'b0, resolution_select_hi = 1'b0, powerdown_serial_pin = 1'b1;
  logic drive_disable_n = 1'b0, chopper_select_pin = 1'b0, ext_clk_level = 1'b0;
  logic power_stage_enable, freewheel, brake, cycle_chopper, index_pulse, ext_clock_active;
  logic [9:0] microstep_position_count, exp_pos = 10'h000, p;
  logic signed [8:0] coil_a_setpoint, coil_b_setpoint;
  logic [4:0] current_scale;
  int errors = 0, n_checks = 0, cycles = 0, idx_count = 0;

  step_dir_microstep_sequencer dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .step, .direction, .double_edge_step_select, .resolution_select_lo, .resolution_select_hi,
    .powerdown_serial_pin, .drive_disable_n, .chopper_select_pin, .ext_clk_level,
    .microstep_position_count, .coil_a_setpoint, .coil_b_setpoint, .current_scale,
    .power_stage_enable, .freewheel, .brake, .cycle_chopper, .index_pulse, .ext_clock_active
  );
  step_source_model partner_u (.aclk, .aresetn, .toggle_req, .dir_req, .step, .direction);

  ////////////////////////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    idx_count <= idx_count + (index_pulse === 1'b1);
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [11:0] a);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // One step-line toggle, then the position must have moved by delta
  task automatic move(input logic dir, input logic [9:0] delta);
    toggle_req <= 1'b1;
    dir_req <= dir;
    @(posedge aclk);
    toggle_req <= 1'b0;
    cyc(6);
    exp_pos = dir ? exp_pos - delta : exp_pos + delta;
    check(microstep_position_count, exp_pos);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(microstep_position_count, 10'h000);
    check(current_scale, 5'h1f);
    rd_reg(`ADDR_POSITION);
    check(rd, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_step_pins;
    logic [9:0] incs [4] = '{10'd32, 10'd8, 10'd4, 10'd16};
    for (int c = 0; c < 4; c++) begin
      resolution_select_hi <= c[1];
      resolution_select_lo <= c[0];
      move(1'b1, incs[c]);
      move(1'b1, 10'h0);
      move(1'b0, incs[c]);
      move(1'b0, 10'h0);
    end
    double_edge_step_select <= 1'b1;
    move(1'b0, 10'd16);
    move(1'b0, 10'd16);
    double_edge_step_select <= 1'b0;
    wr_reg(`ADDR_CONTROL, 32'h1);
    move(1'b1, 10'd16);
    move(1'b1, 10'd16);
    $display("step pin test done");
  endtask

  task automatic t_serial_res;
    logic signed [8:0] ca [4];
    logic signed [8:0] cb [4];
    int i0;
    for (int code = 0; code < 9; code++) begin
      wr_reg(`ADDR_CONTROL, 32'h4 | (code << 4));
      move(1'b0, 10'h1 << code);
      move(1'b0, 10'h0);
      move(1'b1, 10'h1 << code);
      move(1'b1, 10'h0);
    end
    i0 = idx_count;
    for (int k = 0; k < 4; k++) begin
      ca[k] = coil_a_setpoint;
      cb[k] = coil_b_setpoint;
      move(1'b0, 10'd256);
      move(1'b0, 10'h0);
    end
    check(idx_count - i0, 1);
    check(ca[2], -ca[0]);
    check(cb[2], -cb[0]);
    check(ca[3], -ca[1]);
    check(cb[3], -cb[1]);
    $display("serial resolution test done");
  endtask

  task automatic t_internal;
    wr_reg(`ADDR_CONTROL, 32'h6);
    wr_reg(`ADDR_VELOCITY, 32'h0400_0000);
    wr_reg(`ADDR_VELOCITY, 32'h0800_0000);
    cyc(600);
    wr_reg(`ADDR_VELOCITY, 32'h0);
    cyc(3);
    p = microstep_position_count - exp_pos;
    check(p != 10'h0 && p < 10'h200, 1'b1);
    exp_pos = microstep_position_count;
    cyc(300);
    check(microstep_position_count, exp_pos);
    move(1'b0, 10'h1);
    wr_reg(`ADDR_VELOCITY, 32'hf800_0000);
    cyc(600);
    wr_reg(`ADDR_VELOCITY, 32'h0);
    cyc(3);
    p = exp_pos - microstep_position_count;
    check(p != 10'h0 && p < 10'h200, 1'b1);
    $display("internal generator test done");
  endtask

  task automatic t_standstill;
    wr_reg(`ADDR_STANDSTILL, 32'h0004_0112);
    wr_reg(`ADDR_CONTROL, 32'h800);
    powerdown_serial_pin <= 1'b0;
    for (int t = 0; t < 20000 && current_scale !== 5'h12; t++) @(posedge aclk);
    check(current_scale, 5'h12);
    check(freewheel, 1'b1);
    wr_reg(`ADDR_CONTROL, 32'h1000);
    cyc(3);
    check(brake, 1'b1);
    powerdown_serial_pin <= 1'b1;
    wr_reg(`ADDR_CONTROL, 32'h0);
    $display("standstill test done");
  endtask

  task automatic t_misc;
    drive_disable_n <= 1'b1;
    cyc(3);
    check(power_stage_enable, 1'b0);
    drive_disable_n <= 1'b0;
    chopper_select_pin <= 1'b1;
    cyc(3);
    check(power_stage_enable, 1'b1);
    check(cycle_chopper, 1'b1);
    chopper_select_pin <= 1'b0;
    wr_reg(`ADDR_CONTROL, 32'h300);
    cyc(3);
    check(cycle_chopper, 1'b1);
    wr_reg(`ADDR_CONTROL, 32'h100);
    cyc(3);
    check(cycle_chopper, 1'b0);
    wr_reg(`ADDR_STATUS, 32'h0);
    check(resp, `AXI_SLVERR);
    rd_reg(12'h020);
    check(rd, 32'h0);
    check(resp, `AXI_SLVERR);
    wr_reg(`ADDR_CONTROL, 32'h2000);
    check(resp, `AXI_OKAY);
    for (int i = 0; i < 40; i++) begin
      ext_clk_level <= ~ext_clk_level;
      @(posedge aclk);
    end
    check(ext_clock_active, 1'b1);
    cyc(100);
    check(ext_clock_active, 1'b1);
    cyc(160);
    check(ext_clock_active, 1'b0);
    $display("pin and clock test done");
  endtask

  initial begin
    cyc(4);
    aresetn <= 1'b1;
    @(posedge aclk);
    fork
      begin
        t_reset();
        t_step_pins();
        t_serial_res();
        t_internal();
        t_standstill();
        t_misc();
      end
      begin
        wait (cycles >= 60000);
        errors++;
        $display("unexpected at %0t: timeout", $time);
      end
    join_any
    disable fork;
    summarize();
  end
endmodule
